// File: pkg/sipc_params.svh
`ifndef SIPC_PARAMS_SVH
`define SIPC_PARAMS_SVH

// Register byte offsets
`define SIPC_OSC_CTRL_OFS   8'h00
`define SIPC_PWR_CTRL_OFS   8'h04
`define SIPC_CFG_OFS        8'h08
`define SIPC_STATUS_OFS     8'h0C
`define SIPC_UNLOCK_OFS     8'h10
`define SIPC_HALT_IDLE_OFS  8'h14

// Field positions
`define SIPC_SLEEP_SEL_POS  4
`define SIPC_REG_STBY_POS   0
`define SIPC_RET_EN_POS     1
`define SIPC_RET_CFG_POS    2

// Reset values
`define SIPC_OSC_CTRL_RST   32'h0000_0000
`define SIPC_PWR_CTRL_RST   32'h0000_0000
`define SIPC_CFG_RST        32'h0000_0004

// Unlock keys, written in order to the unlock register
`define SIPC_KEY1           32'hAA99_6655
`define SIPC_KEY2           32'h5566_99AA

// Wake-up delays per oscillator class, in ns and in clock cycles
`define SIPC_WAKE_FAST_NS   200
`define SIPC_WAKE_SLOW_NS   1000
`define SIPC_CLK_PERIOD_NS  10
`define SIPC_WAKE_FAST_CYC  ((`SIPC_WAKE_FAST_NS + `SIPC_CLK_PERIOD_NS - 1) / `SIPC_CLK_PERIOD_NS)
`define SIPC_WAKE_SLOW_CYC  ((`SIPC_WAKE_SLOW_NS + `SIPC_CLK_PERIOD_NS - 1) / `SIPC_CLK_PERIOD_NS)

`endif

// File: pkg/sipc_pkg.sv
`default_nettype none
package sipc_pkg;
  typedef enum logic [1:0] {
    SIPC_RUN,
    SIPC_SLEEP,
    SIPC_IDLE,
    SIPC_WAKE
  } sipc_state_t;

  typedef struct packed {
    logic        req;
    logic [2:0]  prio;
  } sipc_irq_t;

  typedef struct packed {
    logic cpu_halt;
    logic sys_clk_en;
    logic pb_clk_en;
    logic fail_mon_en;
    logic reg_standby;
    logic ret_reg_on;
  } sipc_pwr_t;
endpackage
`default_nettype wire

// File: logic/sipc_wake_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sipc_params.svh"

module sipc_wake_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q  <= len_i;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q <= CNT_W'(1)) begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/sipc_power_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sipc_params.svh"

module sipc_power_ctrl
  import sipc_pkg::*;
#(
  parameter int N_PERIPH   = 8,
  parameter int WAKE_CNT_W = 16
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Classic Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Core and interrupt controller
  input  wire logic                  wait_exec_i,
  input  wire logic [2:0]            cpu_prio_i,
  input  wire sipc_pkg::sipc_irq_t   irq_i,
  input  wire logic                  irq_sleep_capable_i,
  input  wire logic                  wdt_timeout_i,
  input  wire logic                  wdt_irq_i,
  input  wire logic                  dev_reset_i,
  input  wire logic                  slow_osc_sel_i,
  input  wire logic                  clk_stable_i,
  input  wire logic                  bor_event_i,
  // Pin drive
  input  wire logic [N_PERIPH-1:0]   pin_drive_i,
  output logic      [N_PERIPH-1:0]   pin_drive_o,
  // Power and clock controls
  output sipc_pkg::sipc_pwr_t        pwr_o,
  output logic      [N_PERIPH-1:0]   periph_run_o,
  output logic                       sleep_periph_en_o,
  output logic                       wdt_run_hold_o,
  output logic                       wdt_sleep_clr_o,
  output logic                       bor_reset_o,
  output logic                       wake_reset_o
);

  // ---------------------------------------------------------------
  // Synchronisers for pin-side inputs
  // ---------------------------------------------------------------
  logic [1:0] bor_sync_q;
  logic [1:0] stable_sync_q;

  always_ff @(posedge clk_i) begin
    bor_sync_q    <= {bor_sync_q[0], bor_event_i};
    stable_sync_q <= {stable_sync_q[0], clk_stable_i};
  end

  logic [N_PERIPH-1:0] pin_s1_q;
  logic [N_PERIPH-1:0] pin_s2_q;

  always_ff @(posedge clk_i) begin
    pin_s1_q <= pin_drive_i;
    pin_s2_q <= pin_s1_q;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]         osc_ctrl_q;
  logic [31:0]         pwr_ctrl_q;
  logic [31:0]         cfg_q;
  logic [N_PERIPH-1:0] halt_idle_q;
  logic [1:0]          unlock_q;
  sipc_state_t         state_q;

  function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SIPC_OSC_CTRL_OFS:  wb_dat_o <= osc_ctrl_q;
          `SIPC_PWR_CTRL_OFS:  wb_dat_o <= pwr_ctrl_q;
          `SIPC_CFG_OFS:       wb_dat_o <= cfg_q;
          `SIPC_STATUS_OFS:    wb_dat_o <= {28'h0000000, unlock_q == 2'h2, 1'b0, state_q};
          `SIPC_HALT_IDLE_OFS: wb_dat_o <= 32'(halt_idle_q);
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Unlock tracker: two keys in order; any other unlock-register write or an oscillator-control write relocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_q <= 2'h0;
    end else if (wb_wr && wb_adr_i == `SIPC_UNLOCK_OFS) begin
      if (wb_dat_i == `SIPC_KEY1) begin
        unlock_q <= 2'h1;
      end else if (wb_dat_i == `SIPC_KEY2 && unlock_q == 2'h1) begin
        unlock_q <= 2'h2;
      end else begin
        unlock_q <= 2'h0;
      end
    end else if (wb_wr && wb_adr_i == `SIPC_OSC_CTRL_OFS) begin
      unlock_q <= 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_ctrl_q <= `SIPC_OSC_CTRL_RST;
    end else if (wb_wr && wb_adr_i == `SIPC_OSC_CTRL_OFS) begin
      osc_ctrl_q <= sel_merge(osc_ctrl_q, wb_dat_i, wb_sel_i);
      if (unlock_q != 2'h2) begin
        osc_ctrl_q[`SIPC_SLEEP_SEL_POS] <= osc_ctrl_q[`SIPC_SLEEP_SEL_POS];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ctrl_q <= `SIPC_PWR_CTRL_RST;
    end else if (wb_wr && wb_adr_i == `SIPC_PWR_CTRL_OFS) begin
      pwr_ctrl_q <= sel_merge(pwr_ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `SIPC_CFG_RST;
    end else if (wb_wr && wb_adr_i == `SIPC_CFG_OFS) begin
      cfg_q <= sel_merge(cfg_q, wb_dat_i, wb_sel_i) & 32'h0000_0004;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_idle_q <= '0;
    end else if (wb_wr && wb_adr_i == `SIPC_HALT_IDLE_OFS) begin
      halt_idle_q <= N_PERIPH'(sel_merge(32'(halt_idle_q), wb_dat_i, wb_sel_i));
    end
  end

  // ---------------------------------------------------------------
  // Wake decision
  // ---------------------------------------------------------------
  logic irq_high;
  logic irq_low;
  logic wake_start;
  logic wake_done;
  logic any_reset;
  logic [WAKE_CNT_W-1:0] wake_len;

  assign irq_high  = irq_i.req && (irq_i.prio > cpu_prio_i);
  assign irq_low   = irq_i.req && (irq_i.prio <= cpu_prio_i);
  assign any_reset = dev_reset_i || bor_sync_q[1];
  assign wake_start = (state_q == SIPC_SLEEP) && !any_reset &&
                      ((irq_high && irq_sleep_capable_i) || wdt_timeout_i);

  assign wake_len = slow_osc_sel_i ? WAKE_CNT_W'(`SIPC_WAKE_SLOW_CYC)
                                   : WAKE_CNT_W'(`SIPC_WAKE_FAST_CYC);

  sipc_wake_timer #(
    .CNT_W (WAKE_CNT_W)
  ) u_wake_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wake_start),
    .len_i   (wake_len),
    .done_o  (wake_done)
  );

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  logic wake_seen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != SIPC_WAKE) begin
      wake_seen_q <= 1'b0;
    end else if (wake_done) begin
      wake_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SIPC_RUN;
    end else if (any_reset) begin
      state_q <= SIPC_RUN;
    end else begin
      case (state_q)
        SIPC_RUN: begin
          if (wait_exec_i) begin
            state_q <= osc_ctrl_q[`SIPC_SLEEP_SEL_POS] ? SIPC_SLEEP : SIPC_IDLE;
          end
        end
        SIPC_SLEEP: begin
          if (wake_start) begin
            state_q <= SIPC_WAKE;
          end else if (irq_low && irq_sleep_capable_i) begin
            state_q <= SIPC_IDLE;
          end
        end
        SIPC_IDLE: begin
          if (irq_high || wdt_irq_i) begin
            state_q <= SIPC_RUN;
          end
        end
        SIPC_WAKE: begin
          if ((wake_done || wake_seen_q) && stable_sync_q[1]) begin
            state_q <= SIPC_RUN;
          end
        end
        default: state_q <= SIPC_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic in_sleep;
  logic in_idle;
  logic entering_sleep;

  assign in_sleep       = (state_q == SIPC_SLEEP);
  assign in_idle        = (state_q == SIPC_IDLE);
  assign entering_sleep = (state_q == SIPC_RUN) && wait_exec_i && !any_reset &&
                          osc_ctrl_q[`SIPC_SLEEP_SEL_POS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_o <= '{cpu_halt: 1'b0, sys_clk_en: 1'b1, pb_clk_en: 1'b1,
                 fail_mon_en: 1'b1, reg_standby: 1'b0, ret_reg_on: 1'b0};
    end else begin
      pwr_o.cpu_halt    <= (state_q != SIPC_RUN);
      pwr_o.sys_clk_en  <= !in_sleep;
      // Peripheral bus clock restarts in Idle
      pwr_o.pb_clk_en   <= !in_sleep;
      pwr_o.fail_mon_en <= !in_sleep;
      pwr_o.reg_standby <= in_sleep && pwr_ctrl_q[`SIPC_REG_STBY_POS];
      pwr_o.ret_reg_on  <= in_sleep && !cfg_q[`SIPC_RET_CFG_POS] &&
                           pwr_ctrl_q[`SIPC_RET_EN_POS];
    end
  end

  // Per-peripheral run enables
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          periph_run_o[gi] <= 1'b1;
        end else begin
          periph_run_o[gi] <= !in_sleep && !(in_idle && halt_idle_q[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_periph_en_o <= 1'b1;
      wdt_run_hold_o    <= 1'b0;
      wdt_sleep_clr_o   <= 1'b0;
      bor_reset_o       <= 1'b0;
      wake_reset_o      <= 1'b0;
      pin_drive_o       <= '0;
    end else begin
      sleep_periph_en_o <= 1'b1;
      // Hold run count, clear sleep count
      wdt_run_hold_o    <= in_sleep;
      wdt_sleep_clr_o   <= entering_sleep;
      bor_reset_o       <= bor_sync_q[1];
      wake_reset_o      <= any_reset && (in_sleep || in_idle);
      if (!in_sleep) begin
        pin_drive_o <= pin_s2_q;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/sipc_power_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sipc_power_ctrl_asserts
  import sipc_pkg::*;
#(
  parameter int N_PERIPH = 8
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic                wait_exec_i,
  input wire logic [2:0]          cpu_prio_i,
  input wire sipc_pkg::sipc_irq_t irq_i,
  input wire logic                irq_sleep_capable_i,
  input wire logic                wdt_timeout_i,
  input wire logic                dev_reset_i,
  input wire logic [N_PERIPH-1:0] pin_drive_o,
  input wire sipc_pkg::sipc_pwr_t pwr_o,
  input wire logic                sleep_periph_en_o,
  input wire logic                wdt_run_hold_o,
  input wire logic                wdt_sleep_clr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Sleep is the only state with the system clock off
  wire logic slp = !pwr_o.sys_clk_en;
  wire logic hi  = irq_i.req && irq_sleep_capable_i && irq_i.prio > cpu_prio_i;
  wire logic lo  = irq_i.req && irq_sleep_capable_i && irq_i.prio <= cpu_prio_i;

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack is not one pulse");
  property p_wait;
    wait_exec_i && !pwr_o.cpu_halt && !dev_reset_i |-> ##2 pwr_o.cpu_halt;
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt the cpu");
  property p_sleep_clk;
    slp |-> pwr_o.cpu_halt && !pwr_o.pb_clk_en && !pwr_o.fail_mon_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("clock left on in sleep");
  property p_wdt;
    $fell(pwr_o.sys_clk_en) |-> $past(wdt_sleep_clr_o) && !wdt_sleep_clr_o && wdt_run_hold_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog counts wrong on sleep");
  property p_periph;
    slp |-> sleep_periph_en_o;
  endproperty
  a_periph: assert property (p_periph) else $error("sleep peripherals off");
  property p_pins;
    slp ##1 slp |-> $stable(pin_drive_o);
  endproperty
  a_pins: assert property (p_pins) else $error("pin drive moved in sleep");
  property p_wake;
    slp && (hi || wdt_timeout_i) |-> ##[1:200] !pwr_o.cpu_halt;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");
  property p_reset;
    dev_reset_i |-> ##2 !pwr_o.cpu_halt;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left cpu halted");
  property p_to_idle;
    slp && lo && !wdt_timeout_i && !dev_reset_i |-> ##2 pwr_o.pb_clk_en && pwr_o.cpu_halt;
  endproperty
  a_to_idle: assert property (p_to_idle) else $error("no drop to idle");
  c_sleep: cover property ($fell(pwr_o.sys_clk_en));
  c_idle: cover property (slp ##1 !slp && pwr_o.cpu_halt);
  c_run: cover property ($fell(pwr_o.cpu_halt));
endmodule
bind sipc_power_ctrl sipc_power_ctrl_asserts #(.N_PERIPH(N_PERIPH)) i_sipc_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wait_exec_i, .cpu_prio_i, .irq_i,
  .irq_sleep_capable_i, .wdt_timeout_i, .dev_reset_i, .pin_drive_o, .pwr_o,
  .sleep_periph_en_o, .wdt_run_hold_o, .wdt_sleep_clr_o
);
`default_nettype wire

// File: tb/sipc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module sipc_osc_model (
  input  wire logic clk_i,
  input  wire logic clk_en_i,
  input  wire logic slow_i,
  output logic      stable_o
);
  int cnt;
  // Oscillator settles only after a restart, longer for the slow source
  always_ff @(posedge clk_i) begin
    if (!clk_en_i) begin
      cnt <= 0;
      stable_o <= 1'b0;
    end else begin
      if (cnt < 30) begin
        cnt <= cnt + 1;
      end
      stable_o <= cnt >= (slow_i ? 30 : 2);
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sipc_params.svh"
module tb_top;
  import sipc_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wait_exec_i;
  logic        irq_sleep_capable_i, wdt_timeout_i, wdt_irq_i, dev_reset_i;
  logic        slow_osc_sel_i, clk_stable_i, bor_event_i, bor_reset_o, wake_reset_o;
  logic [7:0]  wb_adr_i, pin_drive_i, pin_drive_o, periph_run_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0]  cpu_prio_i;
  sipc_irq_t   irq_i;
  sipc_pwr_t   pwr_o;
  logic [10:0] r;
  int          mismatches, tests_run;
  // Row: sleep sel, irq {req,prio}, capable, wdt timeout, wdt irq, slow osc, end state
  logic [10:0] rows [11] = '{11'h760, 11'h764, 11'h6E2, 11'h6A2, 11'h7C1, 11'h410,
                             11'h300, 11'h2C2, 11'h008, 11'h012, 11'h401};
  logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [31:0] rv [5] = '{`SIPC_OSC_CTRL_RST, `SIPC_PWR_CTRL_RST, `SIPC_CFG_RST, 32'h0, 32'h0};

  sipc_power_ctrl #(.N_PERIPH(8)) i_sipc_power_ctrl (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wait_exec_i, .cpu_prio_i, .irq_i, .irq_sleep_capable_i,
    .wdt_timeout_i, .wdt_irq_i, .dev_reset_i, .slow_osc_sel_i, .clk_stable_i, .bor_event_i,
    .pin_drive_i, .pin_drive_o, .pwr_o, .periph_run_o, .sleep_periph_en_o(),
    .wdt_run_hold_o(), .wdt_sleep_clr_o(), .bor_reset_o, .wake_reset_o
  );
  sipc_osc_model i_sipc_osc_model (
    .clk_i, .clk_en_i(pwr_o.sys_clk_en), .slow_i(slow_osc_sel_i), .stable_o(clk_stable_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Classic cycle; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge clk_i);
  endtask

  task automatic unlock;
    bus(1'b1, `SIPC_UNLOCK_OFS, `SIPC_KEY1);
    bus(1'b1, `SIPC_UNLOCK_OFS, `SIPC_KEY2);
  endtask

  task automatic go;
    wait_exec_i <= 1'b1;
    @(posedge clk_i);
    wait_exec_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // Reset from a low-power state must flag itself for one cycle
  task automatic recover(input logic w);
    irq_i <= '0;
    irq_sleep_capable_i <= 1'b0;
    wdt_timeout_i <= 1'b0;
    wdt_irq_i <= 1'b0;
    dev_reset_i <= 1'b1;
    @(posedge clk_i);
    dev_reset_i <= 1'b0;
    @(posedge clk_i);
    chk("wake reset", 32'(w), 32'(wake_reset_o));
    repeat (2) @(posedge clk_i);
    bus(1'b0, `SIPC_STATUS_OFS, 32'h0);
    chk("state after reset", 32'h0, 32'(rd[1:0]));
  endtask

  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wait_exec_i, irq_sleep_capable_i} = '0;
    {wdt_timeout_i, wdt_irq_i, dev_reset_i, slow_osc_sel_i, bor_event_i} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cpu_prio_i = 3'h3;
    irq_i = '0;
    pin_drive_i = 8'h5A;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      r = rows[i];
      slow_osc_sel_i <= r[2];
      unlock();
      bus(1'b1, `SIPC_OSC_CTRL_OFS, {27'h0, r[10], 4'h0});
      go();
      chk("cpu halt", 32'h1, 32'(pwr_o.cpu_halt));
      chk("system clock", 32'(!r[10]), 32'(pwr_o.sys_clk_en));
      irq_i <= r[9:6];
      irq_sleep_capable_i <= r[5];
      wdt_timeout_i <= r[4];
      wdt_irq_i <= r[3];
      repeat (200) @(posedge clk_i);
      bus(1'b0, `SIPC_STATUS_OFS, 32'h0);
      chk("end state", 32'(r[1:0]), 32'(rd[1:0]));
      recover(r[1:0] != 2'h0);
    end
    // Second reset in mid-run, then reset values and an unmapped place
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("power outputs", 32'h1C, 32'(pwr_o));
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk("register", rv[i], rd);
    end
    bus(1'b1, 8'h00, 32'h13);
    bus(1'b0, 8'h00, 32'h0);
    chk("locked select", 32'h3, rd);
    unlock();
    bus(1'b1, 8'h00, 32'h13);
    bus(1'b0, 8'h00, 32'h0);
    chk("unlocked select", 32'h13, rd);
    bus(1'b1, 8'h10, `SIPC_KEY1);
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("wrong key", 32'h10, rd);
    bus(1'b1, 8'h14, 32'hFFFF_FF05, 4'h1);
    bus(1'b0, 8'h14, 32'h0);
    chk("halt in idle", 32'h5, rd);
    unlock();
    bus(1'b1, 8'h00, 32'h0);
    go();
    chk("idle clocks", 32'h3C, 32'(pwr_o));
    chk("idle peripherals", 32'hFA, 32'(periph_run_o));
    recover(1'b1);
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, 8'h04, 32'h3);
      bus(1'b1, 8'h08, c ? 32'h4 : 32'h0);
      unlock();
      bus(1'b1, 8'h00, 32'h10);
      go();
      chk("regulators", c ? 32'h2 : 32'h3, 32'(pwr_o[1:0]));
      pin_drive_i <= ~pin_drive_i;
      repeat (6) @(posedge clk_i);
      chk("held pins", c ? 32'hA5 : 32'h5A, 32'(pin_drive_o));
      bor_event_i <= c[0];
      repeat (6) @(posedge clk_i);
      chk("brown-out", 32'(c), 32'(bor_reset_o));
      bor_event_i <= 1'b0;
      recover(c == 0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
